// ---- common/asd_defs.svh ----
`ifndef ASD_DEFS_SVH
`define ASD_DEFS_SVH

// ---------------------------------------------------------------
// Prefix and single-byte opcodes
// ---------------------------------------------------------------
`define ASD_OPC_SEG_CODE     8'h2E
`define ASD_OPC_SEG_STACK    8'h36
`define ASD_OPC_SEG_DATA     8'h3E
`define ASD_OPC_SEG_EXTRA    8'h26
`define ASD_OPC_ASCII_ADD    8'h37
`define ASD_OPC_DEC_SUM      8'h27
`define ASD_OPC_ASCII_SUB    8'h3F
`define ASD_OPC_DEC_DIFF     8'h2F

// ---------------------------------------------------------------
// Opcode patterns (upper bits)
// ---------------------------------------------------------------
`define ASD_PAT_ADD_RM       6'h00
`define ASD_PAT_ADC_RM       6'h04
`define ASD_PAT_SUB_RM       6'h0A
`define ASD_PAT_BOR_RM       6'h06
`define ASD_PAT_IMM_GRP      6'h20
`define ASD_PAT_ADD_ACC      7'h02
`define ASD_PAT_ADC_ACC      7'h0A
`define ASD_PAT_SUB_ACC      7'h16
`define ASD_PAT_BOR_ACC      7'h0E
`define ASD_PAT_UNARY_GRP    7'h7B

// ---------------------------------------------------------------
// ModR/M sub-opcodes and fields
// ---------------------------------------------------------------
`define ASD_SUB_ADD          3'h0
`define ASD_SUB_ADC          3'h2
`define ASD_SUB_BOR          3'h3
`define ASD_SUB_SUB          3'h5
`define ASD_SUB_FLIP         3'h3
`define ASD_SUB_PROD         3'h4
`define ASD_MOD_REG          2'h3
`define ASD_SW_WORD_IMM      2'h1

// ---------------------------------------------------------------
// Clock budgets
// ---------------------------------------------------------------
`define ASD_CLK_PREFIX       8'h02
`define ASD_CLK_RM_REG       8'h03
`define ASD_CLK_RM_MEM       8'h0A
`define ASD_CLK_IMM_REG      8'h04
`define ASD_CLK_IMM_MEM      8'h10
`define ASD_CLK_ACC_BYTE     8'h03
`define ASD_CLK_ACC_WORD     8'h04
`define ASD_CLK_ASCII_ADD    8'h08
`define ASD_CLK_DEC_SUM      8'h04
`define ASD_CLK_ASCII_SUB    8'h07
`define ASD_CLK_DEC_DIFF     8'h04
`define ASD_CLK_PROD_RB      8'h1C
`define ASD_CLK_PROD_RW      8'h25
`define ASD_CLK_PROD_MB      8'h22
`define ASD_CLK_PROD_MW      8'h2B
`define ASD_CLK_NARROW_XFER  8'h04

`endif

// ---- common/asd_pkg.sv ----
package asd_pkg;

  // ---------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE           = 4'h0,
    OP_SUM            = 4'h1,
    OP_SUM_CARRY      = 4'h2,
    OP_DIFF           = 4'h3,
    OP_DIFF_BORROW    = 4'h4,
    OP_SIGN_FLIP      = 4'h5,
    OP_UPRODUCT       = 4'h6,
    OP_ASCII_ADD_FIX  = 4'h7,
    OP_DEC_SUM_FIX    = 4'h8,
    OP_ASCII_SUB_FIX  = 4'h9,
    OP_DEC_DIFF_FIX   = 4'hA,
    OP_PREFIX         = 4'hB
  } asd_op_e;

  typedef enum logic [2:0] {
    FORM_NONE    = 3'h0,
    FORM_RM      = 3'h1,
    FORM_IMM_RM  = 3'h2,
    FORM_ACC     = 3'h3,
    FORM_UNARY   = 3'h4,
    FORM_IMPLIED = 3'h5
  } asd_form_e;

  typedef enum logic [2:0] {
    SEG_NONE  = 3'h0,
    SEG_CODE  = 3'h1,
    SEG_STACK = 3'h2,
    SEG_DATA  = 3'h3,
    SEG_EXTRA = 3'h4
  } asd_seg_e;

  typedef enum logic [2:0] {
    ST_OPC   = 3'h0,
    ST_MODRM = 3'h1,
    ST_IMLO  = 3'h2,
    ST_IMHI  = 3'h3,
    ST_EXEC  = 3'h4
  } asd_state_e;

  // ---------------------------------------------------------------
  // Decoded instruction
  // ---------------------------------------------------------------
  typedef struct packed {
    asd_op_e    op;
    asd_form_e  form;
    asd_seg_e   seg;
    logic       w;
    logic       d;
    logic       s;
    logic       mem;
    logic [1:0] mode;
    logic [2:0] reg_f;
    logic [2:0] rm;
    logic [15:0] imm;
    logic [7:0] clocks;
  } asd_dec_s;

endpackage

// ---- core/asd_cycle_timer.sv ----
`timescale 1ns/1ps

module asd_cycle_timer #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  // Status
  output logic              last_o
);

  logic [W-1:0] cnt_ff;

  // ---------------------------------------------------------------
  // Down counter
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else if (load_i) begin
      cnt_ff <= count_i;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - W'(1);
    end
  end

  assign last_o = (cnt_ff == W'(1));

endmodule

// ---- core/asd_decoder.sv ----
// Operation
// - Bytes 2E, 36, 3E, 26 set next operand's segment (code, stack, data, extra), 2 clocks.
// - Sum decodes 000000dw+ModR/M (3/10), 100000sw sub 000 (4/16), 0000010w accumulator (3/4).
// - Sum-with-carry decodes 000100dw, 100000sw sub 010, 0001010w with the sum's clocks.
// - Difference decodes 001010dw (3/10), 100000sw sub 101 (4/16), 0010110w accumulator (3/4).
// - Borrowing difference decodes 000110dw, 100000sw sub 011, 0001110w, difference clocks.
// - Immediate-to-r/m forms take a second immediate byte only when s,w is 01.
// - Sign flip decodes 1111011w sub 011, 3 clocks on a register and 10 on memory.
// - ASCII add fix is byte 00110111 and takes 8 clocks on both bus widths.
// - Decimal sum fix is byte 00100111 and takes 4 clocks on both bus widths.
// - ASCII subtract fix is byte 00111111 and takes 7 clocks on both bus widths.
// - Decimal difference fix is byte 00101111 and takes 4 clocks on both bus widths.
// - Unsigned product is 1111011w sub 100: reg byte/word 28/37, mem byte/word 34/43 clocks.
// - On the 8-bit bus, word operands add 4 clocks for every memory transfer.
`timescale 1ns/1ps
`include "asd_defs.svh"

module asd_decoder (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // Bus width strap
  input  wire logic             narrow_bus_i,
  // Prefetch queue
  input  wire logic             q_valid_i,
  input  wire logic [7:0]       q_byte_i,
  output logic                  q_ready_o,
  // Execution unit
  output logic                  dec_valid_o,
  output asd_pkg::asd_dec_s     dec_o,
  output logic                  busy_o,
  output logic                  done_o,
  output logic                  unsup_o
);

  asd_pkg::asd_state_e state_ff;
  asd_pkg::asd_state_e nxt_state;
  asd_pkg::asd_op_e    op_ff;
  asd_pkg::asd_op_e    nxt_op;
  asd_pkg::asd_form_e  form_ff;
  asd_pkg::asd_form_e  nxt_form;
  asd_pkg::asd_seg_e   seg_ff;
  asd_pkg::asd_seg_e   nxt_seg;
  asd_pkg::asd_op_e    c_op;
  asd_pkg::asd_form_e  c_form;
  asd_pkg::asd_seg_e   c_seg;
  asd_pkg::asd_op_e    m_op;
  logic                c_ok;
  logic                m_ok;
  logic                w_ff;
  logic                d_ff;
  logic                s_ff;
  logic                mem_ff;
  logic [1:0]          mode_ff;
  logic [2:0]          reg_ff;
  logic [2:0]          rm_ff;
  logic [15:0]         imm_ff;
  logic                nxt_w;
  logic                nxt_d;
  logic                nxt_s;
  logic                nxt_mem;
  logic [1:0]          nxt_mode;
  logic [2:0]          nxt_reg;
  logic [2:0]          nxt_rm;
  logic [15:0]         nxt_imm;
  logic                nxt_unsup;
  logic                q_ready_ff;
  logic                nb_meta_ff;
  logic                nb_ff;
  logic                take;
  logic                ent_exec;
  logic [7:0]          ent_clk;
  logic                t_last;

  assign take      = q_ready_ff && q_valid_i;
  assign q_ready_o = q_ready_ff;

  // ---------------------------------------------------------------
  // Bus width strap synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      nb_meta_ff <= 1'b0;
      nb_ff      <= 1'b0;
    end else begin
      nb_meta_ff <= narrow_bus_i;
      nb_ff      <= nb_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // Clock budget
  // ---------------------------------------------------------------
  function automatic logic [7:0] clk_budget(asd_pkg::asd_op_e op, asd_pkg::asd_form_e form,
                                            logic mem, logic w, logic d, logic nb);
    logic [7:0] base;
    logic [1:0] xf;
    base = `ASD_CLK_RM_REG;
    xf   = 2'h0;
    case (op)
      asd_pkg::OP_SUM, asd_pkg::OP_SUM_CARRY, asd_pkg::OP_DIFF, asd_pkg::OP_DIFF_BORROW: begin
        if (form == asd_pkg::FORM_ACC) begin
          base = w ? `ASD_CLK_ACC_WORD : `ASD_CLK_ACC_BYTE;
        end else if (form == asd_pkg::FORM_IMM_RM) begin
          base = mem ? `ASD_CLK_IMM_MEM : `ASD_CLK_IMM_REG;
          xf   = 2'h2;
        end else begin
          base = mem ? `ASD_CLK_RM_MEM : `ASD_CLK_RM_REG;
          xf   = d ? 2'h1 : 2'h2;
        end
      end
      asd_pkg::OP_SIGN_FLIP: begin
        base = mem ? `ASD_CLK_RM_MEM : `ASD_CLK_RM_REG;
        xf   = 2'h2;
      end
      asd_pkg::OP_UPRODUCT: begin
        if (mem) begin
          base = w ? `ASD_CLK_PROD_MW : `ASD_CLK_PROD_MB;
        end else begin
          base = w ? `ASD_CLK_PROD_RW : `ASD_CLK_PROD_RB;
        end
        xf = 2'h1;
      end
      asd_pkg::OP_ASCII_ADD_FIX: base = `ASD_CLK_ASCII_ADD;
      asd_pkg::OP_DEC_SUM_FIX:   base = `ASD_CLK_DEC_SUM;
      asd_pkg::OP_ASCII_SUB_FIX: base = `ASD_CLK_ASCII_SUB;
      asd_pkg::OP_DEC_DIFF_FIX:  base = `ASD_CLK_DEC_DIFF;
      asd_pkg::OP_PREFIX:        base = `ASD_CLK_PREFIX;
      default:                   base = `ASD_CLK_RM_REG;
    endcase
    if (nb && w && mem) begin
      base = base + ((xf == 2'h2) ? (`ASD_CLK_NARROW_XFER + `ASD_CLK_NARROW_XFER)
                                  : `ASD_CLK_NARROW_XFER);
    end
    return base;
  endfunction

  // ---------------------------------------------------------------
  // Opcode byte classification
  // ---------------------------------------------------------------
  always_comb begin
    c_op   = asd_pkg::OP_NONE;
    c_form = asd_pkg::FORM_NONE;
    c_seg  = asd_pkg::SEG_NONE;
    c_ok   = 1'b1;
    case (q_byte_i)
      `ASD_OPC_SEG_CODE:  c_seg = asd_pkg::SEG_CODE;
      `ASD_OPC_SEG_STACK: c_seg = asd_pkg::SEG_STACK;
      `ASD_OPC_SEG_DATA:  c_seg = asd_pkg::SEG_DATA;
      `ASD_OPC_SEG_EXTRA: c_seg = asd_pkg::SEG_EXTRA;
      `ASD_OPC_ASCII_ADD: c_op  = asd_pkg::OP_ASCII_ADD_FIX;
      `ASD_OPC_DEC_SUM:   c_op  = asd_pkg::OP_DEC_SUM_FIX;
      `ASD_OPC_ASCII_SUB: c_op  = asd_pkg::OP_ASCII_SUB_FIX;
      `ASD_OPC_DEC_DIFF:  c_op  = asd_pkg::OP_DEC_DIFF_FIX;
      default:            c_ok  = 1'b0;
    endcase
    if (c_seg != asd_pkg::SEG_NONE) begin
      c_op   = asd_pkg::OP_PREFIX;
      c_form = asd_pkg::FORM_IMPLIED;
    end else if (c_ok) begin
      c_form = asd_pkg::FORM_IMPLIED;
    end else begin
      c_ok = 1'b1;
      if (q_byte_i[7:2] == `ASD_PAT_ADD_RM) begin
        c_op   = asd_pkg::OP_SUM;
        c_form = asd_pkg::FORM_RM;
      end else if (q_byte_i[7:2] == `ASD_PAT_ADC_RM) begin
        c_op   = asd_pkg::OP_SUM_CARRY;
        c_form = asd_pkg::FORM_RM;
      end else if (q_byte_i[7:2] == `ASD_PAT_SUB_RM) begin
        c_op   = asd_pkg::OP_DIFF;
        c_form = asd_pkg::FORM_RM;
      end else if (q_byte_i[7:2] == `ASD_PAT_BOR_RM) begin
        c_op   = asd_pkg::OP_DIFF_BORROW;
        c_form = asd_pkg::FORM_RM;
      end else if (q_byte_i[7:2] == `ASD_PAT_IMM_GRP) begin
        c_form = asd_pkg::FORM_IMM_RM;
      end else if (q_byte_i[7:1] == `ASD_PAT_ADD_ACC) begin
        c_op   = asd_pkg::OP_SUM;
        c_form = asd_pkg::FORM_ACC;
      end else if (q_byte_i[7:1] == `ASD_PAT_ADC_ACC) begin
        c_op   = asd_pkg::OP_SUM_CARRY;
        c_form = asd_pkg::FORM_ACC;
      end else if (q_byte_i[7:1] == `ASD_PAT_SUB_ACC) begin
        c_op   = asd_pkg::OP_DIFF;
        c_form = asd_pkg::FORM_ACC;
      end else if (q_byte_i[7:1] == `ASD_PAT_BOR_ACC) begin
        c_op   = asd_pkg::OP_DIFF_BORROW;
        c_form = asd_pkg::FORM_ACC;
      end else if (q_byte_i[7:1] == `ASD_PAT_UNARY_GRP) begin
        c_form = asd_pkg::FORM_UNARY;
      end else begin
        c_ok = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // ModR/M sub-opcode decode
  // ---------------------------------------------------------------
  always_comb begin
    m_op = op_ff;
    m_ok = 1'b1;
    if (form_ff == asd_pkg::FORM_IMM_RM) begin
      case (q_byte_i[5:3])
        `ASD_SUB_ADD: m_op = asd_pkg::OP_SUM;
        `ASD_SUB_ADC: m_op = asd_pkg::OP_SUM_CARRY;
        `ASD_SUB_SUB: m_op = asd_pkg::OP_DIFF;
        `ASD_SUB_BOR: m_op = asd_pkg::OP_DIFF_BORROW;
        default:      m_ok = 1'b0;
      endcase
    end else if (form_ff == asd_pkg::FORM_UNARY) begin
      case (q_byte_i[5:3])
        `ASD_SUB_FLIP: m_op = asd_pkg::OP_SIGN_FLIP;
        `ASD_SUB_PROD: m_op = asd_pkg::OP_UPRODUCT;
        default:      m_ok = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sequencer next state and fields
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_op    = op_ff;
    nxt_form  = form_ff;
    nxt_w     = w_ff;
    nxt_d     = d_ff;
    nxt_s     = s_ff;
    nxt_mem   = mem_ff;
    nxt_mode  = mode_ff;
    nxt_reg   = reg_ff;
    nxt_rm    = rm_ff;
    nxt_imm   = imm_ff;
    nxt_unsup = 1'b0;
    case (state_ff)
      asd_pkg::ST_OPC: if (take) begin
        nxt_op   = c_op;
        nxt_form = c_form;
        nxt_w    = q_byte_i[0];
        nxt_d    = q_byte_i[1];
        nxt_s    = q_byte_i[1];
        nxt_mem  = 1'b0;
        nxt_imm  = '0;
        if (!c_ok) begin
          nxt_unsup = 1'b1;
        end else if (c_form == asd_pkg::FORM_IMPLIED) begin
          nxt_state = asd_pkg::ST_EXEC;
        end else if (c_form == asd_pkg::FORM_ACC) begin
          nxt_state = asd_pkg::ST_IMLO;
        end else begin
          nxt_state = asd_pkg::ST_MODRM;
        end
      end
      asd_pkg::ST_MODRM: if (take) begin
        nxt_op   = m_op;
        nxt_mode = q_byte_i[7:6];
        nxt_reg  = q_byte_i[5:3];
        nxt_rm   = q_byte_i[2:0];
        nxt_mem  = (q_byte_i[7:6] != `ASD_MOD_REG);
        if (!m_ok) begin
          nxt_unsup = 1'b1;
          nxt_state = asd_pkg::ST_OPC;
        end else if (form_ff == asd_pkg::FORM_IMM_RM) begin
          nxt_state = asd_pkg::ST_IMLO;
        end else begin
          nxt_state = asd_pkg::ST_EXEC;
        end
      end
      asd_pkg::ST_IMLO: if (take) begin
        nxt_imm = {(s_ff && form_ff == asd_pkg::FORM_IMM_RM) ? {8{q_byte_i[7]}} : 8'h00,
                   q_byte_i};
        if (form_ff == asd_pkg::FORM_ACC ? w_ff : ({s_ff, w_ff} == `ASD_SW_WORD_IMM)) begin
          nxt_state = asd_pkg::ST_IMHI;
        end else begin
          nxt_state = asd_pkg::ST_EXEC;
        end
      end
      asd_pkg::ST_IMHI: if (take) begin
        nxt_imm   = {q_byte_i, imm_ff[7:0]};
        nxt_state = asd_pkg::ST_EXEC;
      end
      asd_pkg::ST_EXEC: if (t_last) begin
        nxt_state = asd_pkg::ST_OPC;
      end
      default: nxt_state = asd_pkg::ST_OPC;
    endcase
  end

  assign ent_exec = (state_ff != asd_pkg::ST_EXEC) && (nxt_state == asd_pkg::ST_EXEC);
  assign ent_clk  = clk_budget(nxt_op, nxt_form, nxt_mem, nxt_w, nxt_d, nb_ff);

  // ---------------------------------------------------------------
  // Sequencer registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff   <= asd_pkg::ST_OPC;
      q_ready_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      q_ready_ff <= (nxt_state != asd_pkg::ST_EXEC);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      op_ff   <= asd_pkg::OP_NONE;
      form_ff <= asd_pkg::FORM_NONE;
      w_ff    <= 1'b0;
      d_ff    <= 1'b0;
      s_ff    <= 1'b0;
      mem_ff  <= 1'b0;
      mode_ff <= 2'h0;
      reg_ff  <= 3'h0;
      rm_ff   <= 3'h0;
      imm_ff  <= 16'h0000;
    end else begin
      op_ff   <= nxt_op;
      form_ff <= nxt_form;
      w_ff    <= nxt_w;
      d_ff    <= nxt_d;
      s_ff    <= nxt_s;
      mem_ff  <= nxt_mem;
      mode_ff <= nxt_mode;
      reg_ff  <= nxt_reg;
      rm_ff   <= nxt_rm;
      imm_ff  <= nxt_imm;
    end
  end

  // ---------------------------------------------------------------
  // Segment override holding
  // ---------------------------------------------------------------
  always_comb begin
    nxt_seg = seg_ff;
    if (take && state_ff == asd_pkg::ST_OPC && c_seg != asd_pkg::SEG_NONE) begin
      nxt_seg = c_seg;
    end else if (ent_exec) begin
      nxt_seg = asd_pkg::SEG_NONE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      seg_ff <= asd_pkg::SEG_NONE;
    end else begin
      seg_ff <= nxt_seg;
    end
  end

  // ---------------------------------------------------------------
  // Execution timer
  // ---------------------------------------------------------------
  asd_cycle_timer #(.W(8)) u_timer (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .load_i  (ent_exec),
    .count_i (ent_clk),
    .last_o  (t_last)
  );

  // ---------------------------------------------------------------
  // Issue outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dec_valid_o <= 1'b0;
      dec_o       <= '0;
      busy_o      <= 1'b0;
      done_o      <= 1'b0;
      unsup_o     <= 1'b0;
    end else begin
      dec_valid_o <= ent_exec && (nxt_op != asd_pkg::OP_PREFIX);
      busy_o      <= (nxt_state == asd_pkg::ST_EXEC);
      done_o      <= t_last && (state_ff == asd_pkg::ST_EXEC) && (op_ff != asd_pkg::OP_PREFIX);
      unsup_o     <= nxt_unsup;
      if (ent_exec && nxt_op != asd_pkg::OP_PREFIX) begin
        dec_o <= '{op: nxt_op, form: nxt_form, seg: nxt_mem ? seg_ff : asd_pkg::SEG_NONE,
                   w: nxt_w, d: nxt_d, s: nxt_s, mem: nxt_mem, mode: nxt_mode,
                   reg_f: nxt_reg, rm: nxt_rm, imm: nxt_imm, clocks: ent_clk};
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [7:0] run_cnt_ff;
  always_ff @(posedge mclk_i) begin
    if (rst_i || ent_exec) begin
      run_cnt_ff <= 8'h00;
    end else if (state_ff == asd_pkg::ST_EXEC) begin
      run_cnt_ff <= run_cnt_ff + 8'h01;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_prefix_taken;
    state_ff == asd_pkg::ST_OPC && take && c_op == asd_pkg::OP_PREFIX;
  endsequence
  sequence s_two_exec;
    (state_ff == asd_pkg::ST_EXEC) [*2] ##1 (state_ff == asd_pkg::ST_OPC);
  endsequence

  a_prefix_two_clk: assert property (s_prefix_taken |=> s_two_exec)
    else $error("prefix did not take two clocks");
  a_prefix_seg_hold: assert property (s_prefix_taken and (q_byte_i == `ASD_OPC_SEG_DATA)
    |=> seg_ff == asd_pkg::SEG_DATA)
    else $error("data segment prefix not held");
  a_exec_length: assert property (done_o |-> $past(run_cnt_ff) + 8'h01 == dec_o.clocks)
    else $error("execution length differs from budget");
  a_imm_one_byte: assert property (state_ff == asd_pkg::ST_IMLO && take
    && form_ff == asd_pkg::FORM_IMM_RM && {s_ff, w_ff} != `ASD_SW_WORD_IMM
    |=> state_ff == asd_pkg::ST_EXEC)
    else $error("extra immediate byte fetched");
  a_imm_diff_dec: assert property (state_ff == asd_pkg::ST_MODRM && take
    && form_ff == asd_pkg::FORM_IMM_RM && q_byte_i[5:3] == `ASD_SUB_SUB
    |=> op_ff == asd_pkg::OP_DIFF)
    else $error("immediate difference misdecoded");
  a_imm_diff_issue: assert property (dec_valid_o && dec_o.form == asd_pkg::FORM_IMM_RM
    && dec_o.reg_f == `ASD_SUB_SUB |-> dec_o.op == asd_pkg::OP_DIFF)
    else $error("immediate difference issued wrongly");
  a_fix_ascii_add: assert property (dec_valid_o && dec_o.op == asd_pkg::OP_ASCII_ADD_FIX
    |-> dec_o.clocks == `ASD_CLK_ASCII_ADD)
    else $error("ascii add fix budget wrong");
  a_fix_ascii_sub: assert property (dec_valid_o && dec_o.op == asd_pkg::OP_ASCII_SUB_FIX
    |-> dec_o.clocks == `ASD_CLK_ASCII_SUB)
    else $error("ascii subtract fix budget wrong");
  a_fix_decimal: assert property (dec_valid_o && (dec_o.op == asd_pkg::OP_DEC_SUM_FIX
    || dec_o.op == asd_pkg::OP_DEC_DIFF_FIX) |-> dec_o.clocks
    == ((dec_o.op == asd_pkg::OP_DEC_SUM_FIX) ? `ASD_CLK_DEC_SUM : `ASD_CLK_DEC_DIFF))
    else $error("decimal fix budget wrong");
  a_uprod_memword: assert property (dec_valid_o && dec_o.op == asd_pkg::OP_UPRODUCT
    && dec_o.mem && dec_o.w && !nb_ff |-> dec_o.clocks == `ASD_CLK_PROD_MW)
    else $error("product memory word budget wrong");
  a_flip_reg: assert property (dec_valid_o && dec_o.op == asd_pkg::OP_SIGN_FLIP
    && !dec_o.mem |-> dec_o.clocks == `ASD_CLK_RM_REG)
    else $error("sign flip register budget wrong");
  a_narrow_word: assert property (dec_valid_o && dec_o.form == asd_pkg::FORM_RM
    && dec_o.mem && dec_o.w && !dec_o.d && nb_ff
    |-> dec_o.clocks == `ASD_CLK_RM_MEM + `ASD_CLK_NARROW_XFER + `ASD_CLK_NARROW_XFER)
    else $error("narrow bus word penalty wrong");

endmodule

// ---- tb/asd_decoder_tb.sv ----
`timescale 1ns/1ps
module asd_decoder_tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic narrow_bus_i = 1'b0;
  logic slow = 1'b0;
  logic q_valid_i, q_ready_o, dec_valid_o, busy_o, done_o, unsup_o;
  logic [7:0] q_byte_i;
  logic [2:0] ev;
  asd_pkg::asd_dec_s dec_o;
  int fail_count = 0;
  int comparisons = 0;
  assign ev = {unsup_o, done_o, dec_valid_o};
  always #20 mclk_i = ~mclk_i;
  asd_decoder i_asd_decoder (.mclk_i(mclk_i), .rst_i(rst_i), .narrow_bus_i(narrow_bus_i),
    .q_valid_i(q_valid_i), .q_byte_i(q_byte_i), .q_ready_o(q_ready_o),
    .dec_valid_o(dec_valid_o), .dec_o(dec_o), .busy_o(busy_o), .done_o(done_o),
    .unsup_o(unsup_o));
  asd_queue_model i_asd_queue_model (.mclk_i(mclk_i), .q_ready_i(q_ready_o),
    .slow_i(slow), .q_valid_o(q_valid_i), .q_byte_o(q_byte_i));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int k, output int t);
    t = 0;
    do begin @(negedge mclk_i); t++; end while (ev[k] !== 1'b1 && t < 60);
    chk(16'(ev[k]), 16'h1);
    if (ev[k] !== 1'b1) stop_test();
  endtask
  // Feed n bytes, check op and budget, then time done against it
  task automatic run(input int n, input logic [31:0] b, input logic [3:0] op,
                     input logic [7:0] k);
    int t;
    for (int i = n - 1; i >= 0; i--) i_asd_queue_model.put(b[8*i+:8]);
    wt(0, t);
    chk(16'(q_ready_o), 16'h0);
    chk(16'(dec_o.op), 16'(op));
    chk(16'(dec_o.clocks), 16'(k));
    wt(1, t);
    chk(16'(t), 16'(k));
    chk(16'(q_ready_o), 16'h1);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_adjust();
    run(1, 32'h37, 4'h7, 8'h08);
    run(1, 32'h27, 4'h8, 8'h04);
    run(1, 32'h3F, 4'h9, 8'h07);
    run(1, 32'h2F, 4'hA, 8'h04);
    $display("adjust test done");
  endtask
  task automatic t_prefix();
    logic [7:0] pc [4] = '{8'h2E, 8'h36, 8'h3E, 8'h26};
    int t = 0;
    i_asd_queue_model.put(8'h3E);
    repeat (8) begin @(negedge mclk_i); t += int'(busy_o === 1'b1); end
    chk(16'(t), 16'h2);
    run(2, 32'h2907, 4'h3, 8'h0A);
    chk(16'(dec_o.seg), 16'h3);
    for (int i = 0; i < 4; i++) begin
      run(3, {8'h0, pc[i], 16'h0107}, 4'h1, 8'h0A);
      chk(16'(dec_o.seg), 16'(i + 1));
    end
    run(3, 32'h2601C0, 4'h1, 8'h03);
    chk(16'(dec_o.seg), 16'h0);
    run(2, 32'h0107, 4'h1, 8'h0A);
    chk(16'(dec_o.seg), 16'h0);
    $display("prefix test done");
  endtask
  task automatic t_arith();
    run(2, 32'h00C0, 4'h1, 8'h03);
    run(2, 32'h1307, 4'h2, 8'h0A);
    chk(16'({dec_o.d, dec_o.w, dec_o.mode, dec_o.reg_f, dec_o.rm}), 16'h307);
    run(2, 32'h2BC1, 4'h3, 8'h03);
    run(2, 32'h1807, 4'h4, 8'h0A);
    run(4, 32'h81C03412, 4'h1, 8'h04);
    chk(dec_o.imm, 16'h1234);
    run(3, 32'h8317FF, 4'h2, 8'h10);
    chk(dec_o.imm, 16'hFFFF);
    chk(16'({dec_o.s, dec_o.w, dec_o.mem}), 16'h7);
    run(3, 32'h80E87F, 4'h3, 8'h04);
    chk(dec_o.imm, 16'h007F);
    run(3, 32'h82D905, 4'h4, 8'h04);
    run(3, 32'h057856, 4'h1, 8'h04);
    chk(dec_o.imm, 16'h5678);
    chk(16'(dec_o.form), 16'h3);
    run(2, 32'h1411, 4'h2, 8'h03);
    run(2, 32'h2C22, 4'h3, 8'h03);
    run(3, 32'h1D3412, 4'h4, 8'h04);
    $display("arith test done");
  endtask
  task automatic t_unary();
    run(2, 32'hF7D8, 4'h5, 8'h03);
    run(2, 32'hF61F, 4'h5, 8'h0A);
    run(2, 32'hF6E0, 4'h6, 8'h1C);
    run(2, 32'hF7E1, 4'h6, 8'h25);
    run(2, 32'hF627, 4'h6, 8'h22);
    run(2, 32'hF727, 4'h6, 8'h2B);
    $display("unary test done");
  endtask
  task automatic t_narrow();
    narrow_bus_i = 1'b1;
    slow = 1'b1;
    repeat (3) @(negedge mclk_i);
    run(2, 32'hF727, 4'h6, 8'h2F);
    run(2, 32'hF627, 4'h6, 8'h22);
    run(2, 32'h0107, 4'h1, 8'h12);
    run(2, 32'h0307, 4'h1, 8'h0E);
    run(4, 32'h81073412, 4'h1, 8'h18);
    run(2, 32'hF71F, 4'h5, 8'h12);
    run(2, 32'h01C0, 4'h1, 8'h03);
    narrow_bus_i = 1'b0;
    slow = 1'b0;
    $display("narrow test done");
  endtask
  task automatic t_unsup();
    int t;
    i_asd_queue_model.put(8'h40);
    wt(2, t);
    i_asd_queue_model.put(8'hF6);
    i_asd_queue_model.put(8'hC8);
    wt(2, t);
    run(1, 32'h37, 4'h7, 8'h08);
    $display("unsupported test done");
  endtask
  initial begin
    repeat (10) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    t_adjust();
    t_prefix();
    t_arith();
    t_unary();
    t_narrow();
    t_unsup();
    stop_test();
  end
endmodule

// ---- tb/asd_queue_model.sv ----
`timescale 1ns/1ps
module asd_queue_model (
  // Clock and handshake
  input  wire logic       mclk_i,
  input  wire logic       q_ready_i,
  input  wire logic       slow_i,
  // Byte stream
  output logic            q_valid_o,
  output logic [7:0]      q_byte_o
);
  logic [7:0] fifo [$];
  logic       took = 1'b0;
  initial q_valid_o = 1'b0;
  initial q_byte_o = 8'hA5;
  task automatic put(input logic [7:0] b);
    fifo.push_back(b);
  endtask
  always @(posedge mclk_i) took <= q_ready_i & q_valid_o;
  // Idle byte toggles so a stale value never looks valid
  always @(negedge mclk_i) begin
    if (took) void'(fifo.pop_front());
    if (fifo.size() > 0 && !(took && slow_i)) begin
      q_valid_o <= 1'b1;
      q_byte_o <= fifo[0];
    end else begin
      q_valid_o <= 1'b0;
      q_byte_o <= ~q_byte_o;
    end
  end
endmodule
